// file: src/pcibcd_pkg.sv
package pcibcd_pkg;
  // ==================================================
  // bus command codes
  // ==================================================
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [3:0] CMD_MEM_RDM = 4'hc;
  localparam logic [3:0] CMD_MEM_RDL = 4'he;
  localparam logic [3:0] CMD_MEM_WRI = 4'hf;
  // ==================================================
  // configuration address fields
  // ==================================================
  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  localparam logic [1:0] CFG_TYPE1 = 2'h1;
  localparam int BUS_LSB = 16;
  localparam int DEV_LSB = 11;
  localparam int FUNC_LSB = 8;
  localparam logic [4:0] DEV_SPECIAL = 5'h1f;
  localparam logic [2:0] FUNC_SPECIAL = 3'h7;
  // ==================================================
  // timing: medium decode leaves two clocks for faster targets
  // ==================================================
  localparam logic [1:0] DEC_WAIT_CYC = 2'h2;
  localparam logic [1:0] DEC_CNT_RST = 2'h0;
  // ==================================================
  // pending transaction states, gray along idle-fwd-done
  // ==================================================
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FWD = 2'b01,
    ST_DONE = 2'b11
  } pcibcd_state_type;
endpackage

// file: src/pcibcd_txn_track.sv
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// claim decode for both ports
// ==================================================
module pcibcd_claim_decode (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus numbers from the configuration space
  input wire logic [7:0] pri_bus_num,
  input wire logic [7:0] sec_bus_num,
  input wire logic [7:0] sub_bus_num,
  // primary side address phase
  input wire logic up_start,
  input wire logic [3:0] up_cmd,
  input wire logic [31:0] up_addr,
  input wire logic up_hit_down,
  input wire logic up_hit_local,
  input wire logic up_other_sel_n,
  input wire logic up_can_post,
  // primary side answer
  output logic upstream_select_n,
  output logic up_term_normal,
  output logic up_term_retry,
  // secondary side address phase
  input wire logic down_start,
  input wire logic [3:0] down_cmd,
  input wire logic [31:0] down_addr,
  input wire logic down_hit_up,
  input wire logic down_can_post,
  // secondary side answer
  output logic downstream_select_n,
  output logic down_term_normal,
  output logic down_term_retry,
  // forward toward the secondary port
  output logic to_down_valid,
  output logic [3:0] to_down_cmd,
  output logic [31:0] to_down_addr,
  input wire logic to_down_ready,
  input wire logic to_down_done,
  // forward toward the primary port
  output logic to_up_valid,
  output logic [3:0] to_up_cmd,
  output logic [31:0] to_up_addr,
  input wire logic to_up_ready,
  input wire logic to_up_done
);

  // ==================================================
  // primary select from other targets
  // ==================================================
  logic up_sel_meta_reg;
  logic up_sel_sync_reg;

  // two flops on the raw pin; reset to the idle high level so no false select follows reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_sel_meta_reg <= 1'b1;
      up_sel_sync_reg <= 1'b1;
    end else begin
      up_sel_meta_reg <= up_other_sel_n;
      up_sel_sync_reg <= up_sel_meta_reg;
    end
  end

  // ==================================================
  // primary decode window
  // ==================================================
  logic up_busy_reg;
  logic [1:0] up_cnt_reg;
  logic [3:0] up_cmd_reg;
  logic [31:0] up_addr_reg;
  logic up_hit_down_reg;
  logic up_hit_local_reg;
  logic up_seen_reg;
  logic up_decide;
  logic up_claim;

  // window opens on the address phase and closes after the medium decode slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_busy_reg <= 1'b0;
      up_cnt_reg <= pcibcd_pkg::DEC_CNT_RST;
    end else if (up_start) begin
      up_busy_reg <= 1'b1;
      up_cnt_reg <= pcibcd_pkg::DEC_CNT_RST;
    end else if (up_decide) begin
      up_busy_reg <= 1'b0;
    end else if (up_busy_reg) begin
      up_cnt_reg <= up_cnt_reg + 2'h1;
    end
  end

  // address phase held for the whole window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cmd_reg <= 4'h0;
      up_addr_reg <= 32'h0;
      up_hit_down_reg <= 1'b0;
      up_hit_local_reg <= 1'b0;
    end else if (up_start) begin
      up_cmd_reg <= up_cmd;
      up_addr_reg <= up_addr;
      up_hit_down_reg <= up_hit_down;
      up_hit_local_reg <= up_hit_local;
    end
  end

  // another target answered first; sticky until the next address phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_seen_reg <= 1'b0;
    end else if (up_start) begin
      up_seen_reg <= 1'b0;
    end else if (up_busy_reg && !up_sel_sync_reg) begin
      up_seen_reg <= 1'b1;
    end
  end

  // synchroniser lag means a select in the very last slot is only caught live, hence both terms
  assign up_decide = up_busy_reg && (up_cnt_reg == pcibcd_pkg::DEC_WAIT_CYC);
  assign up_claim = up_decide && up_hit_down_reg && !up_hit_local_reg && !up_seen_reg && up_sel_sync_reg;

  // ==================================================
  // secondary decode
  // ==================================================
  logic [7:0] down_bus;
  logic [4:0] down_dev;
  logic [2:0] down_func;
  logic down_cfg_wr;
  logic down_type0;
  logic down_special_req;
  logic down_in_range;
  logic down_to_pri;
  logic down_beyond;
  logic down_passive_cmd;
  logic down_plain;
  logic down_claim;
  logic [3:0] down_fwd_cmd;

  // decided in the address phase itself; the tracker registers the answer
  always_comb begin
    down_bus = down_addr[pcibcd_pkg::BUS_LSB +: 8];
    down_dev = down_addr[pcibcd_pkg::DEV_LSB +: 5];
    down_func = down_addr[pcibcd_pkg::FUNC_LSB +: 3];
    down_cfg_wr = (down_cmd == pcibcd_pkg::CMD_CFG_WR);
    down_type0 = (down_addr[1:0] == pcibcd_pkg::CFG_TYPE0);
    down_special_req = down_cfg_wr && (down_addr[1:0] == pcibcd_pkg::CFG_TYPE1) &&
      (down_dev == pcibcd_pkg::DEV_SPECIAL) && (down_func == pcibcd_pkg::FUNC_SPECIAL);
    down_in_range = (down_bus >= sec_bus_num) && (down_bus <= sub_bus_num);
    down_to_pri = down_special_req && (down_bus == pri_bus_num);
    down_beyond = down_special_req && (down_bus != pri_bus_num) && !down_in_range;
    // configuration and special cycles never pass on the address decode alone
    down_passive_cmd = down_cfg_wr || (down_cmd == pcibcd_pkg::CMD_CFG_RD) ||
      (down_cmd == pcibcd_pkg::CMD_SPECIAL);
    down_plain = !down_passive_cmd && down_hit_up;
    down_claim = down_start && (down_to_pri || down_beyond || down_plain);
    down_fwd_cmd = down_to_pri ? pcibcd_pkg::CMD_SPECIAL : down_cmd;
  end

  // ==================================================
  // one tracker per initiating side
  // ==================================================
  // index 0 serves primary masters, index 1 secondary masters
  wire logic [1:0] side_claim;
  wire logic [3:0] side_cmd [2];
  wire logic [31:0] side_addr [2];
  wire logic [3:0] side_fwd_cmd_in [2];
  wire logic [1:0] side_can_post;
  wire logic [1:0] side_sel_n;
  wire logic [1:0] side_norm;
  wire logic [1:0] side_retry;
  wire logic [1:0] side_fwd_valid;
  wire logic [3:0] side_fwd_cmd [2];
  wire logic [31:0] side_fwd_addr [2];
  wire logic [1:0] side_fwd_ready;
  wire logic [1:0] side_fwd_done;

  // decode results into the per-side arrays
  assign side_claim = {down_claim, up_claim};
  assign side_cmd[0] = up_cmd_reg;
  assign side_cmd[1] = down_cmd;
  assign side_addr[0] = up_addr_reg;
  assign side_addr[1] = down_addr;
  assign side_fwd_cmd_in[0] = up_cmd_reg;
  assign side_fwd_cmd_in[1] = down_fwd_cmd;
  assign side_can_post = {down_can_post, up_can_post};
  assign side_fwd_ready = {to_up_ready, to_down_ready};
  assign side_fwd_done = {to_up_done, to_down_done};

  for (genvar g = 0; g < 2; g++) begin : g_side
    pcibcd_txn_track u_track (
      .clk(clk),
      .rst_n(rst_n),
      .claim(side_claim[g]),
      .claim_cmd(side_cmd[g]),
      .claim_addr(side_addr[g]),
      .fwd_cmd_in(side_fwd_cmd_in[g]),
      .can_post(side_can_post[g]),
      .sel_n(side_sel_n[g]),
      .term_normal(side_norm[g]),
      .term_retry(side_retry[g]),
      .fwd_valid(side_fwd_valid[g]),
      .fwd_cmd(side_fwd_cmd[g]),
      .fwd_addr(side_fwd_addr[g]),
      .fwd_ready(side_fwd_ready[g]),
      .fwd_done(side_fwd_done[g])
    );
  end

  // answers back to the pins; a primary master is forwarded downstream and vice versa
  assign upstream_select_n = side_sel_n[0];
  assign up_term_normal = side_norm[0];
  assign up_term_retry = side_retry[0];
  assign downstream_select_n = side_sel_n[1];
  assign down_term_normal = side_norm[1];
  assign down_term_retry = side_retry[1];
  assign to_down_valid = side_fwd_valid[0];
  assign to_down_cmd = side_fwd_cmd[0];
  assign to_down_addr = side_fwd_addr[0];
  assign to_up_valid = side_fwd_valid[1];
  assign to_up_cmd = side_fwd_cmd[1];
  assign to_up_addr = side_fwd_addr[1];

  // ==================================================
  // decode checks
  // ==================================================
  property p_cfg0_ignored;
    @(posedge clk) disable iff (!rst_n)
    down_start && down_cfg_wr && down_type0 |=> downstream_select_n;
  endproperty
  a_cfg0_ignored: assert property (p_cfg0_ignored) else $error("type 0 write on secondary claimed");

  property p_cfg1_ignored;
    @(posedge clk) disable iff (!rst_n)
    down_start && down_cfg_wr && !down_special_req |=> downstream_select_n;
  endproperty
  a_cfg1_ignored: assert property (p_cfg1_ignored) else $error("plain type 1 write on secondary claimed");

  property p_pri_special;
    @(posedge clk) disable iff (!rst_n)
    down_start && down_to_pri |=> !downstream_select_n && to_up_valid && (to_up_cmd == pcibcd_pkg::CMD_SPECIAL);
  endproperty
  a_pri_special: assert property (p_pri_special) else $error("special request for primary not passed");

  property p_range_ignored;
    @(posedge clk) disable iff (!rst_n)
    down_start && down_special_req && (down_bus != pri_bus_num) && down_in_range |=> downstream_select_n;
  endproperty
  a_range_ignored: assert property (p_range_ignored) else $error("in-range special request claimed");

  property p_special_cmd;
    @(posedge clk) disable iff (!rst_n)
    down_start && (down_cmd == pcibcd_pkg::CMD_SPECIAL) |=> downstream_select_n;
  endproperty
  a_special_cmd: assert property (p_special_cmd) else $error("special cycle on secondary claimed");

  property p_other_select;
    @(posedge clk) disable iff (!rst_n)
    up_busy_reg && (up_seen_reg || !up_sel_sync_reg) |=> upstream_select_n;
  endproperty
  a_other_select: assert property (p_other_select) else $error("claimed over another primary target");

endmodule // pcibcd_claim_decode

// ==================================================
// pending transaction tracker
// ==================================================
module pcibcd_txn_track (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // claimed cycle from the decode
  input wire logic claim,
  input wire logic [3:0] claim_cmd,
  input wire logic [31:0] claim_addr,
  input wire logic [3:0] fwd_cmd_in,
  input wire logic can_post,
  // answer to the initiator
  output logic sel_n,
  output logic term_normal,
  output logic term_retry,
  // request to the opposite port
  output logic fwd_valid,
  output logic [3:0] fwd_cmd,
  output logic [31:0] fwd_addr,
  input wire logic fwd_ready,
  input wire logic fwd_done
);

  // ==================================================
  // pending transaction
  // ==================================================
  pcibcd_pkg::pcibcd_state_type state_reg;
  logic [3:0] held_cmd_reg;
  logic [31:0] held_addr_reg;
  logic posted_reg;
  logic sel_n_reg;
  logic term_normal_reg;
  logic term_retry_reg;
  logic fwd_valid_reg;
  logic [3:0] fwd_cmd_reg;
  logic [31:0] fwd_addr_reg;
  logic accept_new;
  logic repeat_hit;
  logic finish_ok;

  // only one transaction in flight per side; anything else is retried
  assign accept_new = claim && (state_reg == pcibcd_pkg::ST_IDLE);
  assign repeat_hit = claim && (state_reg == pcibcd_pkg::ST_DONE) &&
    (claim_cmd == held_cmd_reg) && (claim_addr == held_addr_reg);
  assign finish_ok = (accept_new && can_post) || repeat_hit;

  // idle, forwarded, completed and waiting for the repeat
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pcibcd_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        pcibcd_pkg::ST_IDLE: begin
          if (accept_new) begin
            state_reg <= pcibcd_pkg::ST_FWD;
          end
        end
        pcibcd_pkg::ST_FWD: begin
          if (fwd_done) begin
            state_reg <= posted_reg ? pcibcd_pkg::ST_IDLE : pcibcd_pkg::ST_DONE;
          end
        end
        pcibcd_pkg::ST_DONE: begin
          if (repeat_hit) begin
            state_reg <= pcibcd_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= pcibcd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // identity of the pending cycle, kept for the repeat match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_cmd_reg <= 4'h0;
      held_addr_reg <= 32'h0;
      posted_reg <= 1'b0;
    end else if (accept_new) begin
      held_cmd_reg <= claim_cmd;
      held_addr_reg <= claim_addr;
      posted_reg <= can_post;
    end
  end

  // one-cycle answer to the initiator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_n_reg <= 1'b1;
      term_normal_reg <= 1'b0;
      term_retry_reg <= 1'b0;
    end else begin
      sel_n_reg <= !claim;
      term_normal_reg <= finish_ok;
      term_retry_reg <= claim && !finish_ok;
    end
  end

  // request to the far port, held until taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_valid_reg <= 1'b0;
      fwd_cmd_reg <= 4'h0;
      fwd_addr_reg <= 32'h0;
    end else if (accept_new) begin
      fwd_valid_reg <= 1'b1;
      fwd_cmd_reg <= fwd_cmd_in;
      fwd_addr_reg <= claim_addr;
    end else if (fwd_valid_reg && fwd_ready) begin
      fwd_valid_reg <= 1'b0;
    end
  end

  assign sel_n = sel_n_reg;
  assign term_normal = term_normal_reg;
  assign term_retry = term_retry_reg;
  assign fwd_valid = fwd_valid_reg;
  assign fwd_cmd = fwd_cmd_reg;
  assign fwd_addr = fwd_addr_reg;

  // ==================================================
  // tracker checks
  // ==================================================
  property p_claim_selects;
    @(posedge clk) disable iff (!rst_n)
    claim |=> !sel_n;
  endproperty
  a_claim_selects: assert property (p_claim_selects) else $error("claimed cycle not selected");

  property p_one_term;
    @(posedge clk) disable iff (!rst_n)
    !(term_normal && term_retry);
  endproperty
  a_one_term: assert property (p_one_term) else $error("normal and retry together");

  property p_repeat_normal;
    @(posedge clk) disable iff (!rst_n)
    repeat_hit |=> term_normal && !fwd_valid;
  endproperty
  a_repeat_normal: assert property (p_repeat_normal) else $error("repeated cycle not ended normally");

  property p_mismatch_retry;
    @(posedge clk) disable iff (!rst_n)
    claim && (state_reg == pcibcd_pkg::ST_DONE) && !repeat_hit |=> term_retry;
  endproperty
  a_mismatch_retry: assert property (p_mismatch_retry) else $error("other cycle taken as the repeat");

  property p_fwd_hold;
    @(posedge clk) disable iff (!rst_n)
    fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_cmd) && $stable(fwd_addr);
  endproperty
  a_fwd_hold: assert property (p_fwd_hold) else $error("forward request dropped before taken");

endmodule // pcibcd_txn_track
`default_nettype wire

// file: dv/pcibcd_far.sv
`timescale 1ns/1ps
`default_nettype none
// far port takes at once, done next clock
module pcibcd_far (
  // clock
  input wire logic clk,
  // forward handshake
  input wire logic v,
  output logic r,
  output logic d
);
  assign r = v;
  // completion one clock after the request is taken
  always_ff @(posedge clk) begin
    d <= v && r;
  end
endmodule // pcibcd_far
`default_nettype wire

// file: dv/tb_pci_bridge_claim_decode.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pci_bridge_claim_decode;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] pri_bus_num = 8'h02;
  logic [7:0] sec_bus_num = 8'h05;
  logic [7:0] sub_bus_num = 8'h08;
  logic up_start = 1'b0;
  logic [3:0] up_cmd = 4'h0;
  logic [31:0] up_addr = 32'h0;
  logic up_hit_down = 1'b0;
  logic up_hit_local = 1'b0;
  logic up_other_sel_n = 1'b1;
  logic up_can_post = 1'b1;
  logic down_start = 1'b0;
  logic [3:0] down_cmd = 4'h0;
  logic [31:0] down_addr = 32'h0;
  logic down_hit_up = 1'b0;
  logic down_can_post = 1'b1;
  logic upstream_select_n;
  logic up_term_normal;
  logic up_term_retry;
  logic downstream_select_n;
  logic down_term_normal;
  logic down_term_retry;
  logic to_down_valid;
  logic [3:0] to_down_cmd;
  logic [31:0] to_down_addr;
  logic to_down_ready;
  logic to_down_done;
  logic to_up_valid;
  logic [3:0] to_up_cmd;
  logic [31:0] to_up_addr;
  logic to_up_ready;
  logic to_up_done;
  logic got_sel;
  logic got_norm;
  logic got_retry;
  logic got_fwd;
  logic [3:0] got_cmd;
  logic [31:0] got_addr;
  int miscompares = 0;
  int samples_checked = 0;

  pcibcd_claim_decode dut (
    .clk(clk),
    .rst_n(rst_n),
    .pri_bus_num(pri_bus_num),
    .sec_bus_num(sec_bus_num),
    .sub_bus_num(sub_bus_num),
    .up_start(up_start),
    .up_cmd(up_cmd),
    .up_addr(up_addr),
    .up_hit_down(up_hit_down),
    .up_hit_local(up_hit_local),
    .up_other_sel_n(up_other_sel_n),
    .up_can_post(up_can_post),
    .upstream_select_n(upstream_select_n),
    .up_term_normal(up_term_normal),
    .up_term_retry(up_term_retry),
    .down_start(down_start),
    .down_cmd(down_cmd),
    .down_addr(down_addr),
    .down_hit_up(down_hit_up),
    .down_can_post(down_can_post),
    .downstream_select_n(downstream_select_n),
    .down_term_normal(down_term_normal),
    .down_term_retry(down_term_retry),
    .to_down_valid(to_down_valid),
    .to_down_cmd(to_down_cmd),
    .to_down_addr(to_down_addr),
    .to_down_ready(to_down_ready),
    .to_down_done(to_down_done),
    .to_up_valid(to_up_valid),
    .to_up_cmd(to_up_cmd),
    .to_up_addr(to_up_addr),
    .to_up_ready(to_up_ready),
    .to_up_done(to_up_done)
  );

  pcibcd_far far_down (
    .clk(clk),
    .v(to_down_valid),
    .r(to_down_ready),
    .d(to_down_done)
  );

  pcibcd_far far_up (
    .clk(clk),
    .v(to_up_valid),
    .r(to_up_ready),
    .d(to_up_done)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [31:0] cfg_addr(input logic [7:0] bus, input logic [4:0] dev, input logic [2:0] fn,
    input logic [1:0] kind);
    cfg_addr = {8'h00, bus, dev, fn, 6'h00, kind};
  endfunction

  // eight clocks of answers after an address phase; side 1 is a secondary master
  task automatic watch(input logic side);
    got_sel = 1'b0;
    got_norm = 1'b0;
    got_retry = 1'b0;
    got_fwd = 1'b0;
    got_cmd = 4'h0;
    got_addr = 32'h0;
    repeat (8) begin
      @(negedge clk);
      if (side ? !downstream_select_n : !upstream_select_n) got_sel = 1'b1;
      if (side ? down_term_normal : up_term_normal) got_norm = 1'b1;
      if (side ? down_term_retry : up_term_retry) got_retry = 1'b1;
      if (side ? to_up_valid : to_down_valid) begin
        got_fwd = 1'b1;
        got_cmd = side ? to_up_cmd : to_down_cmd;
        got_addr = side ? to_up_addr : to_down_addr;
      end
      up_start = 1'b0;
      down_start = 1'b0;
    end
  endtask

  task automatic send_down(input logic [3:0] cmd, input logic [31:0] addr, input logic hit);
    @(negedge clk);
    down_start = 1'b1;
    down_cmd = cmd;
    down_addr = addr;
    down_hit_up = hit;
    watch(1'b1);
  endtask

  task automatic send_up(input logic [3:0] cmd, input logic [31:0] addr, input logic hit_down, input logic hit_local);
    @(negedge clk);
    up_start = 1'b1;
    up_cmd = cmd;
    up_addr = addr;
    up_hit_down = hit_down;
    up_hit_local = hit_local;
    watch(1'b0);
  endtask

  task automatic t_cfg_ignored();
    send_down(pcibcd_pkg::CMD_CFG_WR, cfg_addr(8'h20, 5'h1f, 3'h7, pcibcd_pkg::CFG_TYPE0), 1'b1);
    chk_flag(got_sel, 1'b0);
    send_down(pcibcd_pkg::CMD_CFG_WR, cfg_addr(8'h20, 5'h03, 3'h0, pcibcd_pkg::CFG_TYPE1), 1'b1);
    chk_flag(got_sel, 1'b0);
  endtask

  task automatic t_special_pri();
    send_down(pcibcd_pkg::CMD_CFG_WR, cfg_addr(8'h02, 5'h1f, 3'h7, pcibcd_pkg::CFG_TYPE1), 1'b0);
    chk_flag(got_sel, 1'b1);
    chk_flag(got_fwd, 1'b1);
    chk_word({28'h0, got_cmd}, {28'h0, pcibcd_pkg::CMD_SPECIAL});
  endtask

  task automatic t_special_beyond();
    send_down(pcibcd_pkg::CMD_CFG_WR, cfg_addr(8'h20, 5'h1f, 3'h7, pcibcd_pkg::CFG_TYPE1), 1'b0);
    chk_flag(got_sel, 1'b1);
    chk_word({28'h0, got_cmd}, {28'h0, pcibcd_pkg::CMD_CFG_WR});
    chk_word(got_addr, cfg_addr(8'h20, 5'h1f, 3'h7, pcibcd_pkg::CFG_TYPE1));
  endtask

  task automatic t_special_range();
    send_down(pcibcd_pkg::CMD_CFG_WR, cfg_addr(8'h05, 5'h1f, 3'h7, pcibcd_pkg::CFG_TYPE1), 1'b1);
    chk_flag(got_sel, 1'b0);
    send_down(pcibcd_pkg::CMD_CFG_WR, cfg_addr(8'h08, 5'h1f, 3'h7, pcibcd_pkg::CFG_TYPE1), 1'b1);
    chk_flag(got_sel, 1'b0);
  endtask

  task automatic t_down_passive();
    send_down(pcibcd_pkg::CMD_SPECIAL, 32'h0000_1234, 1'b1);
    chk_flag(got_sel, 1'b0);
    send_down(pcibcd_pkg::CMD_MEM_WR, 32'h0000_4000, 1'b0);
    chk_flag(got_sel, 1'b0);
  endtask

  task automatic t_down_claim();
    send_down(pcibcd_pkg::CMD_MEM_WR, 32'h8000_0040, 1'b1);
    chk_flag(got_sel, 1'b1);
    chk_flag(got_norm, 1'b1);
    chk_flag(got_fwd, 1'b1);
    down_can_post = 1'b0;
    send_down(pcibcd_pkg::CMD_MEM_RD, 32'h8000_0080, 1'b1);
    chk_flag(got_retry, 1'b1);
    chk_flag(got_fwd, 1'b1);
    send_down(pcibcd_pkg::CMD_MEM_RD, 32'h8000_0080, 1'b1);
    chk_flag(got_norm, 1'b1);
    chk_flag(got_fwd, 1'b0);
    down_can_post = 1'b1;
  endtask

  task automatic t_up_no_claim();
    send_up(pcibcd_pkg::CMD_MEM_RD, 32'h1000_0000, 1'b1, 1'b1);
    chk_flag(got_sel, 1'b0);
    send_up(pcibcd_pkg::CMD_MEM_RD, 32'h2000_0000, 1'b0, 1'b0);
    chk_flag(got_sel, 1'b0);
    up_other_sel_n = 1'b0;
    send_up(pcibcd_pkg::CMD_MEM_RD, 32'h3000_0000, 1'b1, 1'b0);
    chk_flag(got_sel, 1'b0);
    up_other_sel_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_up_claim();
    send_up(pcibcd_pkg::CMD_MEM_WR, 32'h3000_0010, 1'b1, 1'b0);
    chk_flag(got_norm, 1'b1);
    chk_word({28'h0, got_cmd}, {28'h0, pcibcd_pkg::CMD_MEM_WR});
    up_can_post = 1'b0;
    send_up(pcibcd_pkg::CMD_MEM_RD, 32'h3000_0020, 1'b1, 1'b0);
    chk_flag(got_retry, 1'b1);
    chk_word(got_addr, 32'h3000_0020);
    send_up(pcibcd_pkg::CMD_MEM_RD, 32'h3000_0024, 1'b1, 1'b0);
    chk_flag(got_retry, 1'b1);
    chk_flag(got_fwd, 1'b0);
    send_up(pcibcd_pkg::CMD_MEM_RD, 32'h3000_0020, 1'b1, 1'b0);
    chk_flag(got_norm, 1'b1);
    up_can_post = 1'b1;
  endtask

  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_cfg_ignored();
    t_special_pri();
    t_special_beyond();
    t_special_range();
    t_down_passive();
    t_down_claim();
    t_up_no_claim();
    t_up_claim();
    end_sim();
  end

  // about twenty address phases of nine clocks each fit well inside this
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule // tb_pci_bridge_claim_decode
`default_nettype wire
